// *** logic/stbc_target.sv ***
/*
 * Target end of the bus: selection response, information transfer
 * handshake, attention and message out retry, REQ/ACK watchdog and the
 * hard reset effects. Received bytes go through a FIFO to the user.
 * Assumes bus lines are synchronous to clock; RST and ATN are resynced.
 */
`timescale 1ns/1ps

// ****************************************
// Byte FIFO
// ****************************************
module stbc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input logic clock,
	input logic rst,
	input logic inValid,
	output logic inReady,
	input logic [WIDTH-1:0] inData,
	output logic outValid,
	input logic outReady,
	output logic [WIDTH-1:0] outData
);
	import stbc_pkg::*;
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0] wr;
		logic [AW:0] rd;
	} stbc_fifo_t;
	stbc_fifo_t q;
	stbc_fifo_t n;

	// Full when pointers differ only in the wrap bit
	assign inReady = (q.wr ^ q.rd) != {1'b1, {AW{1'b0}}};
	assign outValid = q.wr != q.rd;
	assign outData = q.mem[q.rd[AW-1:0]];

	always_comb begin
		n = q;
		if (inValid && inReady) begin
			n.mem[q.wr[AW-1:0]] = inData;
			n.wr = q.wr + 1'b1;
		end
		if (outValid && outReady)
			n.rd = q.rd + 1'b1;
	end

	always_ff @(posedge clock) begin
		if (rst)
			q <= '0;
		else
			q <= n;
	end
endmodule : stbc_fifo

// ****************************************
// Target end
// ****************************************
module stbc_target #(
	parameter logic [2:0] OWN_ID = 3'h0,
	parameter longint unsigned TIMEOUT_CYC = stbc_pkg::TIMEOUT_CYC,
	parameter int FIFO_DEPTH = 32
) (
	input logic clock,
	input logic rst,
	stbc_bus_if.target bus,
	input logic phaseValid,
	input stbc_pkg::stbc_phase_t phaseCode,
	output logic phaseReady,
	input logic busFreeReq,
	input logic outGo,
	input logic txValid,
	input logic [7:0] txData,
	output logic txReady,
	output logic rxValid,
	input logic rxReady,
	output logic [7:0] rxData,
	output logic connected,
	output stbc_pkg::stbc_phase_t phaseNow,
	output logic timeoutEvt,
	output logic msgDone,
	output logic hardReset,
	input logic readyIn,
	input logic resvSet,
	input logic resvRel,
	input logic syncLoad,
	input logic [3:0] syncIn,
	input logic modeLoad,
	input logic [7:0] modeIn,
	input logic senseSet,
	input logic senseTaken,
	input logic statusSet,
	input logic statusTaken,
	input logic uaTaken,
	output logic reserved,
	output logic [3:0] syncOffset,
	output logic [7:0] modeParam,
	output logic senseValid,
	output logic statusPending,
	output logic unitAttention
);
	import stbc_pkg::*;
	typedef struct packed {
		logic rstS1, rstS2, atnS1, atnS2, inRst;
		stbc_tstate_t st;
		stbc_phase_t phase;
		logic bsy, req, dbOn, mustLeave, retry;
		logic [7:0] dbVal;
		logic [TMR_W-1:0] tmr;
		logic toEvt, hrst, done;
		logic resv, sense, pend, ua;
		logic [3:0] syncOff;
		logic [7:0] mode;
	} stbc_target_t;
	stbc_target_t q;
	stbc_target_t n;
	logic [NSIG-1:0] busT;
	logic [NSIG-1:0] oe;
	logic fifoReady;
	logic push;
	logic byteGo;

	// Asserted means low on the wire
	assign busT = ~bus.lineN;
	assign bus.tOut = '0;
	assign bus.tOe = oe;

	stbc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) stbc_fifo_inst (
		.clock(clock),
		.rst(rst),
		.inValid(push),
		.inReady(fifoReady),
		.inData(busT[P_DB0 +: 8]),
		.outValid(rxValid),
		.outReady(rxReady),
		.outData(rxData)
	);

	// Next-state logic
	always_comb begin
		n = q;
		n.rstS1 = busT[P_RST];
		n.rstS2 = q.rstS1;
		n.atnS1 = busT[P_ATN];
		n.atnS2 = q.atnS1;
		n.toEvt = 1'b0;
		n.hrst = 1'b0;
		n.done = 1'b0;
		push = 1'b0;
		txReady = 1'b0;
		phaseReady = 1'b0;
		// Out phases stall REQ while the FIFO is full
		byteGo = q.phase[0] ? txValid : (fifoReady && (q.phase == PH_MOUT ? q.atnS2 : outGo));
		if (resvSet) n.resv = 1'b1;
		if (resvRel) n.resv = 1'b0;
		if (syncLoad) n.syncOff = syncIn;
		if (modeLoad) n.mode = modeIn;
		if (senseTaken) n.sense = 1'b0;
		if (senseSet) n.sense = 1'b1;
		if (statusTaken) n.pend = 1'b0;
		if (statusSet) n.pend = 1'b1;
		if (uaTaken) n.ua = 1'b0;
		case (q.st)
			ST_FREE: begin
				// Selected: SEL true, BSY false, own ID bit on the data lines
				if (busT[P_SEL] && !busT[P_BSY] && !busT[P_IO] && busT[P_DB0 + OWN_ID]) begin
					n.bsy = 1'b1;
					n.st = ST_CONN;
				end
			end
			ST_CONN: begin
				if (busT[P_SEL]) begin
					n.st = ST_CONN;
				end else if (q.atnS2 && q.phase != PH_MOUT) begin
					n.phase = PH_MOUT;
					n.tmr = '0;
					n.st = ST_SETTLE;
				end else if (busFreeReq) begin
					n.bsy = 1'b0;
					n.mustLeave = 1'b0;
					n.phase = PH_DOUT;
					n.st = ST_FREE;
				end else if (phaseValid && !(q.mustLeave && phaseCode == PH_MOUT)) begin
					phaseReady = 1'b1;
					n.phase = phaseCode;
					n.tmr = '0;
					n.st = ST_SETTLE;
				end else if (byteGo) begin
					txReady = q.phase[0];
					n.dbVal = q.phase[0] ? txData : 8'h00;
					n.dbOn = q.phase[0];
					n.req = 1'b1;
					n.tmr = '0;
					n.st = ST_REQ;
				end
			end
			ST_SETTLE: begin
				// Control lines settle before the first REQ
				n.tmr = q.tmr + 1'b1;
				if (q.tmr == TMR_W'(SETTLE_CYC - 1))
					n.st = ST_CONN;
			end
			ST_REQ: begin
				if (busT[P_ACK]) begin
					n.req = 1'b0;
					if (!q.phase[0]) begin
						if (stbcParity(busT[P_DB0 +: 8]) != busT[P_DBP] && q.phase == PH_MOUT)
							n.retry = 1'b1;
						else
							push = 1'b1;
					end
					n.st = ST_ACKW;
				end else if (q.tmr == TMR_W'(TIMEOUT_CYC - 1)) begin
					n.toEvt = 1'b1;
					n.req = 1'b0;
					n.bsy = 1'b0;
					n.dbOn = 1'b0;
					n.retry = 1'b0;
					n.mustLeave = 1'b0;
					n.phase = PH_DOUT;
					n.st = ST_FREE;
				end else begin
					n.tmr = q.tmr + 1'b1;
				end
			end
			ST_ACKW: begin
				if (!busT[P_ACK]) begin
					n.dbOn = 1'b0;
					n.st = ST_CONN;
					if (q.phase != PH_MOUT) begin
						n.mustLeave = 1'b0;
					end else if (q.retry) begin
						n.st = ST_RETRY;
					end else if (!q.atnS2) begin
						n.mustLeave = 1'b1;
						n.done = 1'b1;
					end
				end
			end
			ST_RETRY: begin
				// Same phase, REQ again once ATN is seen false
				if (!q.atnS2) begin
					n.retry = 1'b0;
					n.req = 1'b1;
					n.tmr = '0;
					n.st = ST_REQ;
				end
			end
			default: begin
				n.st = ST_FREE;
			end
		endcase
		// Bus reset overrides the state and settings; the push, txReady, phaseReady, toEvt and done strobes still pass
		if (q.rstS2) begin
			n.st = ST_FREE;
			n.bsy = 1'b0;
			n.req = 1'b0;
			n.dbOn = 1'b0;
			n.retry = 1'b0;
			n.mustLeave = 1'b0;
			n.phase = PH_DOUT;
			n.tmr = '0;
			n.hrst = !q.inRst;
			n.resv = 1'b0;
			n.sense = 1'b0;
			n.syncOff = SYNC_ASYNC;
			n.pend = 1'b0;
			n.ua = q.ua | readyIn;
			n.mode = MODE_DEFAULT;
			n.inRst = 1'b1;
		end else begin
			n.inRst = 1'b0;
		end
	end

	// Line enables; SEL, ACK, ATN and RST are never driven here
	always_comb begin
		oe = '0;
		if (!q.rstS2 && q.st != ST_FREE) begin
			oe[P_BSY] = q.bsy;
			oe[P_MSG] = q.phase[2];
			oe[P_CD] = q.phase[1];
			oe[P_IO] = q.phase[0];
			oe[P_REQ] = q.req;
			if (q.phase[0] && q.dbOn) begin
				oe[P_DB0 +: 8] = q.dbVal;
				oe[P_DBP] = stbcParity(q.dbVal);
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			q <= '0;
			q.st <= ST_FREE;
			q.mode <= MODE_DEFAULT;
			q.syncOff <= SYNC_ASYNC;
		end else begin
			q <= n;
		end
	end

	assign connected = q.st != ST_FREE;
	assign phaseNow = q.phase;
	assign timeoutEvt = q.toEvt;
	assign msgDone = q.done;
	assign hardReset = q.hrst;
	assign reserved = q.resv;
	assign syncOffset = q.syncOff;
	assign modeParam = q.mode;
	assign senseValid = q.sense;
	assign statusPending = q.pend;
	assign unitAttention = q.ua;
endmodule : stbc_target

// *** common/stbc_pkg.sv ***
/*
 * Shared constants and types for the target-side bus condition logic and
 * the initiator end. Assumes a single 200 MHz clock on both ends.
 */
package stbc_pkg;
	// ****************************************
	// Bus line positions in the pin vectors
	// ****************************************
	localparam int NSIG = 18;
	localparam int P_BSY = 0;
	localparam int P_SEL = 1;
	localparam int P_CD = 2;
	localparam int P_IO = 3;
	localparam int P_MSG = 4;
	localparam int P_REQ = 5;
	localparam int P_ACK = 6;
	localparam int P_ATN = 7;
	localparam int P_RST = 8;
	localparam int P_DB0 = 9;
	localparam int P_DBP = 17;

	// ****************************************
	// Timing
	// ****************************************
	localparam longint unsigned CLK_HZ = 200_000_000;
	localparam int CLK_PS = 5000;
	localparam longint unsigned TIMEOUT_S = 30;
	localparam longint unsigned TIMEOUT_CYC = TIMEOUT_S * CLK_HZ;
	localparam int TMR_W = 33;
	localparam int RST_HOLD_NS = 25_000;
	localparam int RST_HOLD_CYC = (RST_HOLD_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int SETTLE_NS = 400;
	localparam int SETTLE_CYC = (SETTLE_NS * 1000 + CLK_PS - 1) / CLK_PS;

	// ****************************************
	// Phases as {MSG, C/D, I/O}, reset values
	// ****************************************
	typedef logic [2:0] stbc_phase_t;
	localparam stbc_phase_t PH_DOUT = 3'h0;
	localparam stbc_phase_t PH_DIN = 3'h1;
	localparam stbc_phase_t PH_CMD = 3'h2;
	localparam stbc_phase_t PH_STAT = 3'h3;
	localparam stbc_phase_t PH_MOUT = 3'h6;
	localparam stbc_phase_t PH_MIN = 3'h7;
	localparam logic [7:0] MODE_DEFAULT = 8'h00;
	localparam logic [3:0] SYNC_ASYNC = 4'h0;

	typedef enum logic [5:0] {
		ST_FREE = 6'h01, ST_CONN = 6'h02, ST_SETTLE = 6'h04,
		ST_REQ = 6'h08, ST_ACKW = 6'h10, ST_RETRY = 6'h20
	} stbc_tstate_t;
	typedef enum logic [5:0] {
		H_FREE = 6'h01, H_SEL = 6'h02, H_CONN = 6'h04,
		H_DATA = 6'h08, H_ACK = 6'h10, H_RST = 6'h20
	} stbc_hstate_t;

	// Asserted value of the parity line: odd parity over the byte
	function automatic logic stbcParity(input logic [7:0] d);
		return ~^d;
	endfunction : stbcParity
endpackage : stbc_pkg

// *** common/stbc_bus_if.sv ***
/*
 * Wired bus between target and initiator ends. Every line is open
 * collector: a driver with its enable high pulls it low. Assumes the
 * testbench instantiates it once and hands the modports to both ends.
 */
`timescale 1ns/1ps
interface stbc_bus_if;
	import stbc_pkg::*;
	logic [NSIG-1:0] tOut;
	logic [NSIG-1:0] tOe;
	logic [NSIG-1:0] iOut;
	logic [NSIG-1:0] iOe;
	logic [NSIG-1:0] lineN;

	// Terminators hold undriven lines high; low level means asserted
	assign lineN = ~((tOe & ~tOut) | (iOe & ~iOut));

	modport target(input lineN, output tOut, output tOe);
	modport initiator(input lineN, output iOut, output iOe);
endinterface : stbc_bus_if

// *** logic/stbc_initiator.sv ***
/*
 * Initiator end of the bus: selection, ATN with a queued message,
 * REQ/ACK answers, message retry replay and reset generation.
 * Assumes the wired bus interface and one clock shared with the target.
 */
`timescale 1ns/1ps
module stbc_initiator #(
	parameter logic [2:0] OWN_ID = 3'h7,
	parameter int HOLD_CYC = stbc_pkg::RST_HOLD_CYC,
	parameter int MSG_DEPTH = 8,
	parameter logic [7:0] FILL_BYTE = 8'h08
) (
	input logic clock,
	input logic rst,
	stbc_bus_if.initiator bus,
	input logic selGo,
	input logic [2:0] selId,
	output logic connected,
	input logic rstGo,
	input logic msgValid,
	input logic [7:0] msgData,
	input logic msgLast,
	output logic msgReady,
	input logic txValid,
	input logic [7:0] txData,
	output logic txReady,
	output logic rxValid,
	output logic [7:0] rxData,
	output stbc_pkg::stbc_phase_t rxPhase,
	output logic rxParErr
);
	import stbc_pkg::*;
	localparam int AW = $clog2(MSG_DEPTH);
	localparam int HW = $clog2(HOLD_CYC + 1);
	typedef struct packed {
		stbc_hstate_t st;
		logic sel, atn, ack, dbOn, loaded, rxV, rxPe;
		logic [7:0] db;
		logic [7:0] rxD;
		stbc_phase_t rxPh;
		logic [HW-1:0] hold;
		logic [MSG_DEPTH-1:0][7:0] mbuf;
		logic [AW:0] cnt;
		logic [AW:0] idx;
	} stbc_init_t;
	stbc_init_t q;
	stbc_init_t n;
	logic [NSIG-1:0] busT;
	stbc_phase_t ph;
	logic [AW:0] sendIdx;

	assign busT = ~bus.lineN;
	assign ph = {busT[P_MSG], busT[P_CD], busT[P_IO]};
	assign msgReady = !q.loaded && q.cnt < (AW + 1)'(MSG_DEPTH);

	// Next-state logic
	always_comb begin
		n = q;
		n.rxV = 1'b0;
		txReady = 1'b0;
		// A REQ after the whole message went out is a retry: start over
		sendIdx = (q.idx >= q.cnt) ? '0 : q.idx;
		if (msgValid && msgReady) begin
			n.mbuf[q.cnt[AW-1:0]] = msgData;
			n.cnt = q.cnt + 1'b1;
			n.loaded = msgLast || q.cnt == (AW + 1)'(MSG_DEPTH - 1);
		end
		case (q.st)
			H_FREE: begin
				if (selGo && !busT[P_BSY] && !busT[P_SEL]) begin
					n.sel = 1'b1;
					n.db = 8'h00;
					n.db[selId] = 1'b1;
					n.db[OWN_ID] = 1'b1;
					n.dbOn = 1'b1;
					n.atn = q.loaded;
					n.st = H_SEL;
				end
			end
			H_SEL: begin
				if (busT[P_BSY] || !selGo) begin
					n.sel = 1'b0;
					n.dbOn = 1'b0;
					n.atn = q.atn && busT[P_BSY];
					n.st = busT[P_BSY] ? H_CONN : H_FREE;
				end
			end
			H_CONN: begin
				if (!busT[P_BSY]) begin
					n.atn = 1'b0;
					n.cnt = '0;
					n.idx = '0;
					n.loaded = 1'b0;
					n.st = H_FREE;
				end else if (busT[P_REQ] && ph[0]) begin
					n.rxV = 1'b1;
					n.rxD = busT[P_DB0 +: 8];
					n.rxPh = ph;
					n.rxPe = stbcParity(busT[P_DB0 +: 8]) != busT[P_DBP];
					n.ack = 1'b1;
					n.st = H_ACK;
				end else if (busT[P_REQ] && ph == PH_MOUT) begin
					n.db = (q.cnt == '0) ? FILL_BYTE : q.mbuf[sendIdx[AW-1:0]];
					n.idx = sendIdx + 1'b1;
					// ATN stays up only while further bytes follow this one
					n.atn = (sendIdx + 1'b1) < q.cnt;
					n.dbOn = 1'b1;
					n.st = H_DATA;
				end else if (busT[P_REQ] && txValid) begin
					if (q.loaded && q.idx == q.cnt) begin
						n.cnt = '0;
						n.idx = '0;
						n.loaded = 1'b0;
					end
					txReady = 1'b1;
					n.db = txData;
					n.dbOn = 1'b1;
					n.st = H_DATA;
				end else if (q.loaded && q.idx == '0) begin
					n.atn = 1'b1;
				end
			end
			H_DATA: begin
				// Data and ATN stand one cycle before ACK
				n.ack = 1'b1;
				n.st = H_ACK;
			end
			H_ACK: begin
				if (!busT[P_REQ]) begin
					n.ack = 1'b0;
					n.dbOn = 1'b0;
					n.st = H_CONN;
				end
			end
			H_RST: begin
				n.hold = q.hold + 1'b1;
				if (q.hold == HW'(HOLD_CYC - 1))
					n.st = H_FREE;
			end
			default: begin
				n.st = H_FREE;
			end
		endcase
		// Own reset from any state but H_RST, or someone else's: let go of every line but RST next edge
		if ((rstGo || busT[P_RST]) && q.st != H_RST) begin
			n.st = rstGo ? H_RST : H_FREE;
			n.hold = '0;
			n.sel = 1'b0;
			n.atn = 1'b0;
			n.ack = 1'b0;
			n.dbOn = 1'b0;
			n.cnt = '0;
			n.idx = '0;
			n.loaded = 1'b0;
		end
	end

	// Line enables; BSY, C/D, I/O, MSG and REQ are left to the target
	always_comb begin
		bus.iOe = '0;
		bus.iOe[P_RST] = q.st == H_RST;
		bus.iOe[P_SEL] = q.sel;
		bus.iOe[P_ATN] = q.atn;
		bus.iOe[P_ACK] = q.ack;
		if (q.dbOn) begin
			bus.iOe[P_DB0 +: 8] = q.db;
			bus.iOe[P_DBP] = stbcParity(q.db);
		end
	end
	assign bus.iOut = '0;

	always_ff @(posedge clock) begin
		if (rst) begin
			q <= '0;
			q.st <= H_FREE;
		end else begin
			q <= n;
		end
	end

	assign connected = q.st == H_CONN || q.st == H_DATA || q.st == H_ACK;
	assign rxValid = q.rxV;
	assign rxData = q.rxD;
	assign rxPhase = q.rxPh;
	assign rxParErr = q.rxPe;
endmodule : stbc_initiator

// *** tb/stbc_checker.sv ***
/*
 * Bus-side assertions for the target and initiator ends.
 * Assumes plain copies of the wired bus signals and one shared clock.
 */
`timescale 1ns/1ps
module stbc_checker #(
	parameter int TIMEOUT_CYC = 200,
	parameter int HOLD_CYC = 20
) (
	input logic clock,
	input logic rst,
	input logic [stbc_pkg::NSIG-1:0] tOut,
	input logic [stbc_pkg::NSIG-1:0] tOe,
	input logic [stbc_pkg::NSIG-1:0] iOut,
	input logic [stbc_pkg::NSIG-1:0] iOe,
	input logic [stbc_pkg::NSIG-1:0] lineN
);
	import stbc_pkg::*;
	typedef struct packed {
		logic [31:0] waitCnt;
		logic [31:0] lowCnt;
	} stbc_chk_t;
	stbc_chk_t cnt_reg;
	stbc_chk_t cnt_next;

	// Unanswered REQ cycles and RST low cycles
	always_comb begin
		cnt_next = cnt_reg;
		cnt_next.waitCnt = (tOe[P_REQ] && lineN[P_ACK]) ? cnt_reg.waitCnt + 32'h1 : 32'h0;
		cnt_next.lowCnt = !lineN[P_RST] ? cnt_reg.lowCnt + 32'h1 : 32'h0;
	end
	always_ff @(posedge clock) begin
		if (rst) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	// ****************************************
	// Properties
	// ****************************************
	sequence s_rstSeen; $fell(lineN[P_RST]); endsequence
	// Two idle cycles: allows one cycle of skew while the target lets go
	sequence s_busIdle; (lineN[P_BSY] && lineN[P_SEL]) [*2]; endsequence
	property p_noRst; !tOe[P_RST]; endproperty
	property p_release;
		s_rstSeen |-> ##4 (tOe == '0 && {iOe[NSIG-1:P_RST+1], iOe[P_RST-1:0]} == '0);
	endproperty
	property p_freeQuiet; s_busIdle |-> tOe == '0; endproperty
	property p_tgtRoles; !tOe[P_SEL] && !tOe[P_ACK] && !tOe[P_ATN]; endproperty
	property p_iniRoles; iOe[P_REQ:P_CD] == '0; endproperty
	property p_dataDir; (|tOe[P_DBP:P_DB0]) |-> tOe[P_IO]; endproperty
	property p_toCap; cnt_reg.waitCnt <= TIMEOUT_CYC + 4; endproperty
	property p_toEarly;
		$fell(tOe[P_REQ]) && lineN[P_ACK] && lineN[P_RST] |-> cnt_reg.waitCnt >= TIMEOUT_CYC - 2;
	endproperty
	property p_rstHold; $rose(lineN[P_RST]) |-> cnt_reg.lowCnt >= HOLD_CYC; endproperty
	// Open collector: a driver may only pull a line low
	property p_pullOnly; tOut == '0 && iOut == '0; endproperty

	a_noRst: assert property (p_noRst) else $error("target drove RST");
	a_release: assert property (p_release) else $error("lines held after RST");
	a_freeQuiet: assert property (p_freeQuiet) else $error("target drives in bus free");
	a_tgtRoles: assert property (p_tgtRoles) else $error("target drove host line");
	a_iniRoles: assert property (p_iniRoles) else $error("host drove target line");
	a_dataDir: assert property (p_dataDir) else $error("target data without I/O");
	a_toCap: assert property (p_toCap) else $error("REQ outlived timeout");
	a_toEarly: assert property (p_toEarly) else $error("REQ dropped early");
	a_rstHold: assert property (p_rstHold) else $error("RST pulse too short");
	a_pullOnly: assert property (p_pullOnly) else $error("line driven high");
endmodule : stbc_checker

// *** tb/scsi_target_bus_conditions_tb_top.sv ***
/*
 * Testbench joining target and initiator ends over the wired bus.
 * Assumes shortened timeout and reset hold parameters.
 */
`timescale 1ns/1ps
module scsi_target_bus_conditions_tb_top;
	import stbc_pkg::*;
	localparam int TO = 200;
	localparam int HOLD = 20;
	logic clock = '0, rst = '1, iHold = '0;
	logic phaseValid = '0, busFreeReq = '0, outGo = '0, txValid = '0, rxReady = '0;
	logic readyIn = '0, resvSet = '0, resvRel = '0, syncLoad = '0, modeLoad = '0;
	logic senseSet = '0, senseTaken = '0, statusSet = '0, statusTaken = '0, uaTaken = '0;
	logic [7:0] txData = '0, modeIn = '0, rxData, modeParam, msgData = '0, iTxData = '0, iRxData;
	logic [3:0] syncIn = '0, syncOffset;
	stbc_phase_t phaseCode = PH_DOUT, phaseNow, iRxPhase;
	logic phaseReady, txReady, rxValid, connected, timeoutEvt, msgDone, hardReset, reserved;
	logic senseValid, statusPending, unitAttention, iConn, msgReady, iTxReady, iRxValid;
	logic iRxParErr, selGo = '0, rstGo = '0, msgValid = '0, msgLast = '0, iTxValid = '0;
	logic [2:0] selId = '0;
	logic [7:0] rxQ[$];
	int error_cnt = 0, samples_checked = 0, n;

	stbc_bus_if bus();
	stbc_target #(.TIMEOUT_CYC(TO)) stbc_target_inst (.clock, .rst, .bus, .phaseValid, .phaseCode,
		.phaseReady, .busFreeReq, .outGo, .txValid, .txData, .txReady, .rxValid, .rxReady, .rxData,
		.connected, .phaseNow, .timeoutEvt, .msgDone, .hardReset, .readyIn, .resvSet, .resvRel,
		.syncLoad, .syncIn, .modeLoad, .modeIn, .senseSet, .senseTaken, .statusSet, .statusTaken,
		.uaTaken, .reserved, .syncOffset, .modeParam, .senseValid, .statusPending, .unitAttention);
	stbc_initiator #(.HOLD_CYC(HOLD)) stbc_initiator_inst (.clock, .rst(rst | iHold), .bus,
		.selGo, .selId, .connected(iConn), .rstGo, .msgValid, .msgData, .msgLast, .msgReady,
		.txValid(iTxValid), .txData(iTxData), .txReady(iTxReady), .rxValid(iRxValid),
		.rxData(iRxData), .rxPhase(iRxPhase), .rxParErr(iRxParErr));
	stbc_checker #(.TIMEOUT_CYC(TO), .HOLD_CYC(HOLD)) stbc_checker_inst (.clock, .rst,
		.tOut(bus.tOut), .tOe(bus.tOe), .iOut(bus.iOut), .iOe(bus.iOe), .lineN(bus.lineN));

	// 200 MHz clock
	always #2.5 clock = ~clock;
	// Bytes popped from the target FIFO, sampled before the edge updates
	always @(posedge clock) begin
		if (rxValid && rxReady) rxQ.push_back(rxData);
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("FAIL %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : chk
	task tick;
		@(posedge clock);
		#1;
	endtask : tick
	task conclude;
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : conclude
	task select;
		selGo = 1;
		repeat (300) if (connected !== 1'b1 || iConn !== 1'b1) tick;
		selGo = 0;
		chk(connected, 1);
	endtask : select
	task setPhase(input stbc_phase_t c);
		phaseCode = c;
		phaseValid = 1;
		#1; // Ready is combinational: let it settle first
		repeat (300) if (phaseReady !== 1'b1) tick;
		chk(phaseReady, 1);
		tick;
		phaseValid = 0;
	endtask : setPhase
	// Target to host byte; host copy compared
	task sendIn(input logic [7:0] d);
		txData = d;
		txValid = 1;
		#1; // Ready is combinational: let it settle first
		repeat (300) if (txReady !== 1'b1) tick;
		tick;
		txValid = 0;
		repeat (300) if (iRxValid !== 1'b1) tick;
		chk(iRxData, d);
	endtask : sendIn
	task push(input logic [7:0] d, input logic l);
		msgData = d;
		msgLast = l;
		msgValid = 1;
		repeat (20) if (msgReady !== 1'b1) tick;
		tick;
	endtask : push

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		repeat (12) @(posedge clock);
		#1 rst = 0;
		chk(bus.lineN, 18'h3ffff);
		select();
		chk(bus.lineN[P_BSY], 0);
		setPhase(PH_DIN);
		sendIn(8'ha5);
		chk(iRxPhase, PH_DIN);
		chk(iRxParErr, 0);
		setPhase(PH_MIN);
		sendIn(8'h3c);
		chk(iRxPhase, PH_MIN);
		$display("test select_in finished");
		// Fill the FIFO from the host until the target stops asking
		setPhase(PH_DOUT);
		outGo = 1;
		iTxValid = 1;
		n = 0;
		for (int i = 0; i < 33; i++) begin
			iTxData = 8'(i);
			repeat (300) if (iTxReady !== 1'b1) tick;
			if (iTxReady === 1'b1) begin
				n++;
				tick;
			end
		end
		chk(n, 32);
		iTxValid = 0;
		outGo = 0;
		rxReady = 1;
		repeat (200) tick;
		chk(rxQ.size(), 32);
		for (int i = 0; i < 32; i++) chk(rxQ[i], i);
		rxQ.delete();
		$display("test fifo_fill finished");
		// Two-byte message; ATN pulls the target into message out
		push(8'h81, 0);
		push(8'h06, 1);
		msgValid = 0;
		repeat (900) if (msgDone !== 1'b1) tick;
		chk(msgDone, 1);
		repeat (10) tick;
		chk(rxQ.size(), 2);
		chk(rxQ[0], 8'h81);
		chk(rxQ[1], 8'h06);
		phaseCode = PH_MOUT;
		phaseValid = 1;
		n = 0;
		repeat (40) begin
			tick;
			if (phaseReady === 1'b1) n++;
		end
		phaseValid = 0;
		chk(n, 0);
		tick;
		setPhase(PH_STAT);
		sendIn(8'h00);
		chk(iRxPhase, PH_STAT);
		chk(phaseNow, PH_STAT);
		// User ends the connection; both ends let go of every line
		busFreeReq = 1;
		repeat (20) if (connected !== 1'b0) tick;
		busFreeReq = 0;
		chk(connected, 0);
		tick;
		chk(iConn, 0);
		chk(bus.lineN, 18'h3ffff);
		chk(phaseNow, PH_DOUT);
		$display("test message_out finished");
		// Host held in reset so REQ is never answered
		select();
		iHold = 1;
		setPhase(PH_DIN);
		txData = 8'h5a;
		txValid = 1;
		#1;
		repeat (300) if (txReady !== 1'b1) tick;
		tick;
		txValid = 0;
		n = 0;
		while (timeoutEvt !== 1'b1 && n < 400) begin
			tick;
			n++;
		end
		chk(n >= TO - 2 && n <= TO + 4, 1);
		tick;
		chk(connected, 0);
		iHold = 0;
		$display("test timeout finished");
		// Load host settings, then a bus reset from the host
		select();
		{resvSet, syncLoad, modeLoad, senseSet, statusSet, readyIn} = '1;
		syncIn = 4'h5;
		modeIn = 8'h3c;
		tick;
		{resvSet, syncLoad, modeLoad, senseSet, statusSet} = '0;
		tick;
		chk({reserved, syncOffset, modeParam, senseValid, statusPending}, 15'h54f3);
		rstGo = 1;
		tick;
		rstGo = 0;
		chk(bus.lineN[P_RST], 0);
		repeat (40) if (hardReset !== 1'b1) tick;
		chk(hardReset, 1);
		repeat (40) tick;
		chk(reserved, 0);
		chk(senseValid, 0);
		chk(syncOffset, SYNC_ASYNC);
		chk(statusPending, 0);
		chk(unitAttention, 1);
		chk(modeParam, MODE_DEFAULT);
		chk({connected, iConn}, 0);
		uaTaken = 1;
		tick;
		uaTaken = 0;
		tick;
		chk(unitAttention, 0);
		$display("test hard_reset finished");
		conclude();
	end

	// Hang guard, far beyond the expected run length
	initial begin
		repeat (20000) @(posedge clock);
		error_cnt++;
		$display("FAIL %0t watchdog expired", $time);
		conclude();
	end
endmodule : scsi_target_bus_conditions_tb_top
